// >>> rtl/fcr_map.svh
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH
// ==========================================================
// Command opcodes
`define FCR_OP_WR_FUNC 8'h42
`define FCR_OP_SET_RD_NV 8'h65
`define FCR_OP_SET_RD_V_A 8'hC0
`define FCR_OP_SET_RD_V_B 8'h63
`define FCR_OP_SET_XRD_NV 8'h85
// ==========================================================
// Function register fields
`define FCR_FN_RST_DIS 0
`define FCR_FN_SIDE 1
`define FCR_FN_PROGRAM_PAUSED_FLAG 2
`define FCR_FN_ERASE_PAUSED_FLAG 3
`define FCR_FN_LOCK_LO 4
`define FCR_FN_OTP_MASK 8'hF3
// ==========================================================
// Read parameter fields
`define FCR_RP_BURST_LO 0
`define FCR_RP_WRAP 2
`define FCR_RP_DUMMY_LO 3
`define FCR_RP_PINSEL 7
`define FCR_RP_RESET 8'h00
`define FCR_BURST_MIN 7'h08
// ==========================================================
// Non-volatile store word addresses
`define FCR_NV_FUNC 2'h0
`define FCR_NV_RD 2'h1
`define FCR_NV_XRD 2'h2
`define FCR_NV_LAST 2'h2
`define FCR_NV_RESET 8'h00
`endif

// >>> rtl/fcr_pkg.sv
`default_nettype none
package fcr_pkg;
	// Power-up load sequencer
	typedef enum logic [1:0] {ST_FETCH, ST_TAKE, ST_RUN} fcr_state_e;
	// Function of the shared pause/restart pin
	typedef enum logic [1:0] {PIN_PAUSE, PIN_RESTART, PIN_DATA3} fcr_pin_e;
	// Decoded serial command with its data byte
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] data;
	} fcr_cmd_s;
	// Suspend and resume events of the program/erase engine
	typedef struct packed {
		logic prog_suspend;
		logic prog_resume;
		logic erase_suspend;
		logic erase_resume;
	} fcr_susp_s;
endpackage
`default_nettype wire

// >>> rtl/fcr_nv_store.sv
`include "fcr_map.svh"
`default_nettype none
module fcr_nv_store import fcr_pkg::*; (
	input wire logic clock, // System clock
	input wire logic resetn, // Async reset, low
	input wire logic wr_en, // Write strobe
	input wire logic [1:0] wr_addr, // Write word
	input wire logic [7:0] wr_data, // Write byte
	input wire logic [1:0] rd_addr, // Read word
	output var logic [7:0] rd_data // Registered read byte
);
	// ==========================================================
	// Storage
	logic [7:0] mem_q [4];
	logic [7:0] mem_d [4];
	logic [7:0] rd_data_d;

	// Next contents and read data
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (wr_en) begin
			mem_d[wr_addr] = wr_data;
		end
		rd_data_d = mem_q[rd_addr];
	end

	// Register the array and the read port
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++) begin
				mem_q[i] <= `FCR_NV_RESET;
			end
			rd_data <= `FCR_NV_RESET;
		end else begin
			mem_q <= mem_d;
			rd_data <= rd_data_d;
		end
	end
endmodule // fcr_nv_store
`default_nettype wire

// >>> rtl/fcr_regs.sv
`include "fcr_map.svh"
`default_nettype none
module fcr_regs import fcr_pkg::*; (
	input wire logic clock, // System clock, 100 MHz
	input wire logic resetn, // Async reset, low
	input wire fcr_cmd_s cmd, // Decoded register command
	input wire fcr_susp_s susp, // Suspend/resume events
	input wire logic quad_io_enable, // Quad enable from status register
	input wire logic four_wire_command_mode, // Four-wire command mode active
	input wire logic has_dedicated_restart, // Variant strap: dedicated restart pin
	input wire logic restart_disable_default, // Variant strap: default of bit 0
	output logic load_done, // Power-up load finished
	output logic [7:0] function_config, // Function register image
	output logic [7:0] read_parameters, // Volatile read parameters
	output logic [7:0] ext_read_parameters, // Volatile extended parameters
	output logic program_paused_flag, // Program suspended
	output logic erase_paused_flag, // Erase suspended
	output logic protect_side_select, // 0 top, 1 bottom
	output logic [3:0] info_row_lock, // Information row locks
	output logic restart_on_dedicated_pin, // Dedicated restart pin active
	output fcr_pin_e shared_pin_func, // Shared pin function
	output logic guard_pin_is_data_line_two, // Write-guard pin is data line two
	output logic [3:0] dummy_cycles, // Dummy cycle field
	output logic dummy_use_default, // Use command's default dummy count
	output logic wrap_enable_bit, // Wrap within burst
	output logic [6:0] burst_bytes // Burst length in bytes
);
	// ==========================================================
	// Helpers
	function automatic logic [6:0] burst_len(input logic [1:0] sel);
		burst_len = `FCR_BURST_MIN << sel;
	endfunction

	function automatic logic is_op(input fcr_cmd_s c, input logic [7:0] op);
		is_op = c.valid && (c.opcode == op);
	endfunction

	// ==========================================================
	// State
	fcr_state_e st_q, st_d;
	logic [1:0] idx_q, idx_d;
	logic [7:0] otp_q, otp_d;
	logic [7:0] rd_vol_q, rd_vol_d;
	logic [7:0] xrd_vol_q, xrd_vol_d;
	logic program_paused_flag_q, program_paused_flag_d;
	logic erase_paused_flag_q, erase_paused_flag_d;
	logic ded_q, ded_d;
	logic dis_def_q, dis_def_d;
	logic [1:0] strap_s1_q, strap_s2_q; // Strap pins through two flops
	logic nv_wr;
	logic [1:0] nv_wr_addr;
	logic [7:0] nv_wr_data;
	logic [7:0] nv_rd_data;
	logic run;
	logic rst_dis;

	assign run = (st_q == ST_RUN);

	// ==========================================================
	// Persistent copies
	fcr_nv_store u_store (
		.clock(clock),
		.resetn(resetn),
		.wr_en(nv_wr),
		.wr_addr(nv_wr_addr),
		.wr_data(nv_wr_data),
		.rd_addr(idx_q),
		.rd_data(nv_rd_data)
	);

	// ==========================================================
	// Load sequencer and command handling
	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		otp_d = otp_q;
		rd_vol_d = rd_vol_q;
		xrd_vol_d = xrd_vol_q;
		ded_d = ded_q;
		dis_def_d = dis_def_q;
		nv_wr = 1'b0;
		nv_wr_addr = `FCR_NV_FUNC;
		nv_wr_data = 8'h00;
		case (st_q)
			ST_FETCH: begin
				// Straps taken from the second sync stage only
				ded_d = strap_s2_q[1];
				dis_def_d = strap_s2_q[0];
				st_d = ST_TAKE;
			end
			ST_TAKE: begin
				case (idx_q)
					`FCR_NV_FUNC: otp_d = nv_rd_data & `FCR_FN_OTP_MASK;
					`FCR_NV_RD: rd_vol_d = nv_rd_data;
					default: xrd_vol_d = nv_rd_data;
				endcase
				if (idx_q == `FCR_NV_LAST) begin
					st_d = ST_RUN;
				end else begin
					idx_d = idx_q + 2'h1;
					st_d = ST_FETCH;
				end
			end
			ST_RUN: begin
				if (is_op(cmd, `FCR_OP_WR_FUNC)) begin
					// One-time bits only accumulate ones
					otp_d = otp_q | (cmd.data & `FCR_FN_OTP_MASK);
					nv_wr = 1'b1;
					nv_wr_addr = `FCR_NV_FUNC;
					nv_wr_data = otp_d;
				end else if (is_op(cmd, `FCR_OP_SET_RD_NV)) begin
					nv_wr = 1'b1;
					nv_wr_addr = `FCR_NV_RD;
					nv_wr_data = cmd.data;
				end else if (is_op(cmd, `FCR_OP_SET_RD_V_A) || is_op(cmd, `FCR_OP_SET_RD_V_B)) begin
					rd_vol_d = cmd.data;
				end else if (is_op(cmd, `FCR_OP_SET_XRD_NV)) begin
					nv_wr = 1'b1;
					nv_wr_addr = `FCR_NV_XRD;
					nv_wr_data = cmd.data;
				end
			end
			default: st_d = ST_FETCH;
		endcase
	end

	// Suspend flags: set wins over resume, no command reaches them
	always_comb begin
		program_paused_flag_d = program_paused_flag_q;
		erase_paused_flag_d = erase_paused_flag_q;
		if (susp.prog_resume) program_paused_flag_d = 1'b0;
		if (susp.prog_suspend) program_paused_flag_d = 1'b1;
		if (susp.erase_resume) erase_paused_flag_d = 1'b0;
		if (susp.erase_suspend) erase_paused_flag_d = 1'b1;
	end

	// Register all state; strap pins cross in through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_FETCH;
			idx_q <= `FCR_NV_FUNC;
			otp_q <= `FCR_NV_RESET;
			rd_vol_q <= `FCR_RP_RESET;
			xrd_vol_q <= `FCR_NV_RESET;
			program_paused_flag_q <= 1'b0;
			erase_paused_flag_q <= 1'b0;
			ded_q <= 1'b0;
			dis_def_q <= 1'b0;
			strap_s1_q <= 2'b00;
			strap_s2_q <= 2'b00;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			otp_q <= otp_d;
			rd_vol_q <= rd_vol_d;
			xrd_vol_q <= xrd_vol_d;
			program_paused_flag_q <= program_paused_flag_d;
			erase_paused_flag_q <= erase_paused_flag_d;
			ded_q <= ded_d;
			dis_def_q <= dis_def_d;
			strap_s1_q <= {has_dedicated_restart, restart_disable_default};
			strap_s2_q <= strap_s1_q;
		end
	end

	// ==========================================================
	// Decoded outputs
	assign rst_dis = otp_q[`FCR_FN_RST_DIS] | dis_def_q;
	assign load_done = run;
	assign function_config = {otp_q[7:4], erase_paused_flag_q, program_paused_flag_q, otp_q[`FCR_FN_SIDE], rst_dis};
	assign read_parameters = rd_vol_q;
	assign ext_read_parameters = xrd_vol_q;
	assign program_paused_flag = program_paused_flag_q;
	assign erase_paused_flag = erase_paused_flag_q;
	assign protect_side_select = otp_q[`FCR_FN_SIDE];
	assign info_row_lock = otp_q[`FCR_FN_LOCK_LO +: 4];
	assign restart_on_dedicated_pin = ded_q && !rst_dis;
	assign guard_pin_is_data_line_two = quad_io_enable;
	assign dummy_cycles = rd_vol_q[`FCR_RP_DUMMY_LO +: 4];
	assign dummy_use_default = (dummy_cycles == 4'h0);
	assign wrap_enable_bit = rd_vol_q[`FCR_RP_WRAP];
	assign burst_bytes = burst_len(rd_vol_q[`FCR_RP_BURST_LO +: 2]);

	// Shared pin: data line in quad use, else pause or restart
	always_comb begin
		if (quad_io_enable || four_wire_command_mode) begin
			shared_pin_func = PIN_DATA3;
		end else if (restart_on_dedicated_pin) begin
			shared_pin_func = PIN_PAUSE;
		end else if (rd_vol_q[`FCR_RP_PINSEL]) begin
			shared_pin_func = PIN_RESTART;
		end else begin
			shared_pin_func = PIN_PAUSE;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_otp_sticky;
		run && $past(run) |-> (($past(otp_q) & ~otp_q) == 8'h00);
	endproperty
	a_otp_sticky: assert property (p_otp_sticky) else $error("one-time bit fell");

	property p_program_paused_flag_set;
		susp.prog_suspend |=> program_paused_flag;
	endproperty
	a_program_paused_flag_set: assert property (p_program_paused_flag_set) else $error("program flag not set");

	property p_erase_paused_flag_clr;
		susp.erase_resume && !susp.erase_suspend |=> !erase_paused_flag;
	endproperty
	a_erase_paused_flag_clr: assert property (p_erase_paused_flag_clr) else $error("erase flag not cleared");

	property p_flag_hold;
		is_op(cmd, `FCR_OP_WR_FUNC) && susp == 4'h0 |=> $stable(program_paused_flag_q) && $stable(erase_paused_flag_q);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("write moved suspend flag");

	property p_quad_pin;
		quad_io_enable || four_wire_command_mode |-> shared_pin_func == PIN_DATA3;
	endproperty
	a_quad_pin: assert property (p_quad_pin) else $error("shared pin not data");

	property p_ded_pause;
		ded_q && !rst_dis && !quad_io_enable && !four_wire_command_mode
			|-> shared_pin_func == PIN_PAUSE;
	endproperty
	a_ded_pause: assert property (p_ded_pause) else $error("dedicated case not pause");

	property p_vol_write;
		run && (is_op(cmd, `FCR_OP_SET_RD_V_A) || is_op(cmd, `FCR_OP_SET_RD_V_B))
			|=> read_parameters == $past(cmd.data);
	endproperty
	a_vol_write: assert property (p_vol_write) else $error("volatile write lost");

	property p_nv_write;
		run && is_op(cmd, `FCR_OP_SET_RD_NV)
			|-> nv_wr && nv_wr_addr == `FCR_NV_RD && nv_wr_data == cmd.data
			##1 $stable(rd_vol_q);
	endproperty
	a_nv_write: assert property (p_nv_write) else $error("persistent write misrouted");

	property p_load;
		st_q == ST_TAKE && idx_q == `FCR_NV_RD |=> rd_vol_q == $past(nv_rd_data);
	endproperty
	a_load: assert property (p_load) else $error("volatile copy not loaded");

	property p_burst;
		(rd_vol_q[1:0] == 2'b00 && burst_bytes == 7'h08)
			|| (rd_vol_q[1:0] == 2'b01 && burst_bytes == 7'h10)
			|| (rd_vol_q[1:0] == 2'b10 && burst_bytes == 7'h20)
			|| (rd_vol_q[1:0] == 2'b11 && burst_bytes == 7'h40);
	endproperty
	a_burst: assert property (p_burst) else $error("burst length wrong");
endmodule // fcr_regs
`default_nettype wire

// >>> tb/fcr_host_model.sv
`default_nettype none
module fcr_host_model import fcr_pkg::*; (
	input wire logic clock, // Bench clock
	output var fcr_cmd_s cmd, // Decoded command toward the registers
	output var fcr_susp_s susp // Program/erase engine events
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========================================
	// Idle bus at time zero
	initial begin
		cmd = '{1'b0, 8'h00, 8'h00};
		susp = '0;
	end
	// One command byte; released bus carries scrambled values
	task automatic send(input logic [7:0] op, input logic [7:0] dat);
		@(negedge clock) cmd <= '{1'b1, op, dat};
		@(negedge clock) cmd <= '{1'b0, ~op, ~dat};
	endtask
	// One-cycle event pulse from the engine
	task automatic pulse(input logic [3:0] ev);
		@(negedge clock) susp <= ev;
		@(negedge clock) susp <= '0;
	endtask
endmodule // fcr_host_model
`default_nettype wire

// >>> tb/test_flash_config_param_registers.sv
`include "fcr_map.svh"
`default_nettype none
module test_flash_config_param_registers import fcr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ========================================
	// Signals
	logic clock, resetn, quad, fw, ded, strap, load_done;
	fcr_cmd_s cmd;
	fcr_susp_s susp;
	logic [7:0] function_config, read_parameters, ext_read_parameters, d, fexp;
	logic program_paused_flag, erase_paused_flag, protect_side_select;
	logic restart_on_dedicated_pin, guard_pin_is_data_line_two;
	logic dummy_use_default, wrap_enable_bit;
	logic [3:0] info_row_lock, dummy_cycles;
	logic [6:0] burst_bytes;
	fcr_pin_e shared_pin_func;
	int bad_count = 0;
	int num_checks = 0;
	int seed = 32'hf87b4553;
	localparam logic [7:0] CORNER [3] = '{8'h00, 8'hFF, 8'h08};
	// ========================================
	// Clock and instances
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	fcr_host_model fcr_host_model_i (.clock(clock), .cmd(cmd), .susp(susp));
	fcr_regs fcr_regs_i (.clock(clock), .resetn(resetn), .cmd(cmd), .susp(susp),
		.quad_io_enable(quad), .four_wire_command_mode(fw), .has_dedicated_restart(ded),
		.restart_disable_default(strap), .load_done(load_done),
		.function_config(function_config), .read_parameters(read_parameters),
		.ext_read_parameters(ext_read_parameters), .program_paused_flag(program_paused_flag),
		.erase_paused_flag(erase_paused_flag), .protect_side_select(protect_side_select),
		.info_row_lock(info_row_lock), .restart_on_dedicated_pin(restart_on_dedicated_pin),
		.shared_pin_func(shared_pin_func),
		.guard_pin_is_data_line_two(guard_pin_is_data_line_two),
		.dummy_cycles(dummy_cycles), .dummy_use_default(dummy_use_default),
		.wrap_enable_bit(wrap_enable_bit), .burst_bytes(burst_bytes));
	// ========================================
	// Verdict, comparison and expectations
	task automatic complete_run();
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	// Shared pin: data in quad modes, pause while dedicated restart is live
	function automatic logic [1:0] exp_pin(input logic p7, input logic b0);
		if (quad || fw) return 2'(PIN_DATA3);
		if (ded && !b0) return 2'(PIN_PAUSE);
		return p7 ? 2'(PIN_RESTART) : 2'(PIN_PAUSE);
	endfunction
	// Sweep quad, four-wire mode and the pin select bit
	task automatic pin_sweep(input logic b0);
		for (int j = 0; j < 8; j++) begin
			quad = j[0];
			fw = j[1];
			fcr_host_model_i.send(`FCR_OP_SET_RD_V_A, {j[2], 7'h00});
			chk(8'(shared_pin_func), 8'(exp_pin(j[2], b0)));
			chk(8'(restart_on_dedicated_pin), 8'(ded && !b0));
			chk(8'(guard_pin_is_data_line_two), 8'(quad));
		end
		quad = 1'b0;
		fw = 1'b0;
	endtask
	// ========================================
	// Main sequence: three variant straps, each after a fresh reset
	initial begin
		resetn = 1'b0;
		quad = 1'b0;
		fw = 1'b0;
		ded = 1'b1;
		strap = 1'b0;
		for (int ph = 0; ph < 3; ph++) begin
			ded = (ph != 2);
			strap = (ph == 1);
			resetn = 1'b0;
			repeat (8) @(negedge clock);
			resetn = 1'b1;
			for (int n = 0; n < 20 && load_done !== 1'b1; n++) @(negedge clock);
			if (load_done !== 1'b1) begin
				bad_count++;
				complete_run();
			end
			chk(function_config, {7'h00, strap});
			chk(read_parameters, 8'h00);
			chk(ext_read_parameters, 8'h00);
			chk(8'(burst_bytes), 8'h08);
			pin_sweep(strap);
			for (int i = 0; i < 24; i++) begin
				d = (i < 3) ? CORNER[i] : 8'($random(seed));
				fcr_host_model_i.send(i[0] ? `FCR_OP_SET_RD_V_B : `FCR_OP_SET_RD_V_A, d);
				chk(read_parameters, d);
				chk(8'(dummy_cycles), 8'(d[6:3]));
				chk(8'(dummy_use_default), 8'(d[6:3] == 4'h0));
				chk(8'(wrap_enable_bit), 8'(d[2]));
				chk(8'(burst_bytes), 8'h08 << d[1:0]);
			end
			fcr_host_model_i.send(`FCR_OP_SET_RD_NV, ~d);
			chk(read_parameters, d);
			fcr_host_model_i.send(`FCR_OP_SET_XRD_NV, d);
			chk(ext_read_parameters, 8'h00);
			fexp = {4'hF, 2'b00, 1'b1, strap};
			fcr_host_model_i.send(`FCR_OP_WR_FUNC, 8'hFE);
			chk(function_config, fexp);
			chk({info_row_lock, 3'h0, protect_side_select}, 8'hF1);
			fcr_host_model_i.send(`FCR_OP_WR_FUNC, 8'h00);
			chk(function_config, fexp);
			for (int k = 0; k < 2; k++) begin
				fcr_host_model_i.pulse(k ? 4'b0010 : 4'b1000);
				chk({program_paused_flag, erase_paused_flag}, k ? 8'h01 : 8'h02);
				fcr_host_model_i.pulse(k ? 4'b0011 : 4'b1100);
				chk(8'(function_config[3:2]), k ? 8'h02 : 8'h01);
				fcr_host_model_i.send(`FCR_OP_WR_FUNC, 8'h00);
				chk(8'(function_config[3:2]), k ? 8'h02 : 8'h01);
				fcr_host_model_i.pulse(k ? 4'b0001 : 4'b0100);
				chk({program_paused_flag, erase_paused_flag}, 8'h00);
			end
			fcr_host_model_i.send(`FCR_OP_WR_FUNC, 8'h01);
			chk(8'(function_config[0]), 8'h01);
			pin_sweep(1'b1);
		end
		complete_run();
	end
endmodule // test_flash_config_param_registers
`default_nettype wire
